// ==== lcs_pkg.sv ====
// shared constants and types for the data 3/4 input select block
package lcs_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          LCS_ADDR_W        = 4;
    localparam logic [3:0]  LCS_SEL_OFFSET    = 4'h0;
    localparam logic [3:0]  LCS_GATE_OFFSET   = 4'h1;
    localparam logic [3:0]  LCS_STAT_OFFSET   = 4'h2;
    localparam int          LCS_DATA_W        = 8;
    localparam int          LCS_IN_W          = 16;
    localparam int          LCS_CODE_W        = 3;
    localparam int          LCS_GATES         = 4;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          LCS_CH3_LSB       = 0;
    localparam int          LCS_CH4_LSB       = 4;
    // per gate: bit 0 inverted ch3, 1 true ch3, 2 inverted ch4, 3 true ch4
    localparam int          LCS_EN_W          = 4;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0]  LCS_CODE_RST      = 3'h0;
    localparam logic [15:0] LCS_GATE_EN_RST   = 16'h0000;
    // mapping: input index = code + base (mod 16)
    localparam logic [3:0]  LCS_CH3_BASE      = 4'h8;
    localparam logic [3:0]  LCS_CH4_BASE      = 4'hc;
endpackage : lcs_pkg

// ==== lcs_sel_if.sv ====
// routing codes and selected data passed between the block's modules
`timescale 1ns/1ps
`default_nettype none
interface lcs_sel_if;
    logic [2:0] chan3_source_code;
    logic [2:0] chan4_source_code;
    logic       chan3_data;
    logic       chan4_data;
    modport ctrl (output chan3_source_code, output chan4_source_code, input chan3_data, input chan4_data);
    modport mux  (input chan3_source_code, input chan4_source_code, output chan3_data, output chan4_data);
endinterface : lcs_sel_if
`default_nettype wire

// ==== lcs_mux.sv ====
// selects one line of the synchronised input bus for each data channel
`timescale 1ns/1ps
`default_nettype none
module lcs_mux
    import lcs_pkg::*;
#(
    parameter int IN_W = LCS_IN_W
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                clk_en,
    input  wire logic [IN_W-1:0]     cell_input_bus,
    lcs_sel_if.mux                   sel
);
    typedef struct packed {
        logic [IN_W-1:0] sync1;
        logic [IN_W-1:0] sync2;
    } lcs_mux_state_type;

    lcs_mux_state_type state_q;
    lcs_mux_state_type state_d;
    logic [3:0]        idx3;
    logic [3:0]        idx4;

    always_comb begin
        state_d       = state_q;
        state_d.sync1 = cell_input_bus;
        state_d.sync2 = state_q.sync1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // wrapping add gives 8..15 for ch3 and 12..15,0..3 for ch4
    assign idx3 = 4'({1'b0, sel.chan3_source_code} + LCS_CH3_BASE); // [RULE_02] [RULE_03]
    assign idx4 = 4'({1'b0, sel.chan4_source_code} + LCS_CH4_BASE); // [RULE_01]
    assign sel.chan3_data = state_q.sync2[idx3];
    assign sel.chan4_data = state_q.sync2[idx4];

    AST_CH4_LOW: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
        sel.chan4_source_code[2] |-> sel.chan4_data == state_q.sync2[sel.chan4_source_code[1:0]])
        else $error("chan4 low-input routing wrong");
    AST_CH4_HIGH: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
        !sel.chan4_source_code[2] |-> sel.chan4_data == state_q.sync2[{2'h3, sel.chan4_source_code[1:0]}])
        else $error("chan4 high-input routing wrong");
    AST_CH3_MAP: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_02]
        sel.chan3_data == state_q.sync2[{1'b1, sel.chan3_source_code}])
        else $error("chan3 routing wrong");
    AST_CH3_LOWCODES: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
        (sel.chan3_source_code == 3'h0) |-> sel.chan3_data == state_q.sync2[8])
        else $error("chan3 code 0 not input 8");
endmodule : lcs_mux
`default_nettype wire

// ==== lcs_gate_fan.sv ====
// offers each selected channel in true and inverted form to each gate
`timescale 1ns/1ps
`default_nettype none
module lcs_gate_fan
    import lcs_pkg::*;
#(
    parameter int GATES = LCS_GATES
) (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         clk_en,
    input  wire logic                         chan3_data,
    input  wire logic                         chan4_data,
    input  wire logic [GATES*LCS_EN_W-1:0]    gate_en,
    output logic      [GATES*LCS_EN_W-1:0]    gate_terms
);
    typedef struct packed {
        logic [GATES*LCS_EN_W-1:0] terms;
    } lcs_fan_state_type;

    lcs_fan_state_type state_q;
    lcs_fan_state_type state_d;
    logic [LCS_EN_W-1:0] forms;

    assign forms = {chan4_data, ~chan4_data, chan3_data, ~chan3_data}; // [RULE_07]

    always_comb begin
        state_d       = state_q;
        state_d.terms = '0;
        for (int g = 0; g < GATES; g++) begin
            state_d.terms[g*LCS_EN_W +: LCS_EN_W] = forms & gate_en[g*LCS_EN_W +: LCS_EN_W]; // [RULE_07]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    assign gate_terms = state_q.terms;

    AST_GATE_TRUE4: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_07]
        clk_en && gate_en[3] |=> gate_terms[3] == $past(chan4_data))
        else $error("true chan4 term not gated into gate 0");
    AST_GATE_OFF: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_07]
        clk_en && gate_en == '0 |=> gate_terms == '0)
        else $error("disabled terms leaked into gates");
endmodule : lcs_gate_fan
`default_nettype wire

// ==== lcs_top.sv ====
// data 3/4 input select register with its routing and gate fan-out
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE_01] ch4 code bits 6:4; codes 4..7 pick inputs 0..3, codes 0..3 inputs 12..15
// [RULE_02] ch3 code bits 2:0; codes 7 down to 2 pick inputs 15 down to 10
// [RULE_03] ch3 codes 1 and 0 pick inputs 9 and 8
// [RULE_04] bits 7 and 3 are unimplemented: read zero, writes ignored
// [RULE_05] codes undefined after power-on; other resets keep them
// [RULE_06] both code fields read and write, each write steers routing
// [RULE_07] each channel goes true and inverted to each gate under enable bits; here only gates 0 and 1 can be enabled, gates 2 and 3 stay off
module lcs_top
    import lcs_pkg::*;
#(
    parameter int IN_W  = LCS_IN_W,
    parameter int GATES = LCS_GATES
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       clk_en,
    input  wire logic                       soft_rst,
    input  wire logic [LCS_ADDR_W-1:0]      reg_addr,
    input  wire logic [LCS_DATA_W-1:0]      reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [LCS_DATA_W-1:0]      reg_rdata,
    input  wire logic [IN_W-1:0]            cell_input_bus,
    output logic                            chan3_data,
    output logic                            chan4_data,
    output logic      [GATES*LCS_EN_W-1:0]  gate_terms
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]                chan3_code;
        logic [2:0]                chan4_code;
        logic [GATES*LCS_EN_W-1:0] gate_en;
        logic [LCS_DATA_W-1:0]     rdata;
        logic                      ch3_out;
        logic                      ch4_out;
    } lcs_top_state_type;

    lcs_top_state_type state_q;
    lcs_top_state_type state_d;
    lcs_sel_if         sel_bus ();

    // ------------------------------------------------------------
    // register writes and reads
    // ------------------------------------------------------------
    // soft_rst stands for every reset other than power-on: it leaves the codes alone
    always_comb begin
        state_d         = state_q;
        state_d.rdata   = '0;
        state_d.ch3_out = sel_bus.chan3_data;
        state_d.ch4_out = sel_bus.chan4_data;
        if (soft_rst) begin
            state_d.gate_en = LCS_GATE_EN_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                LCS_SEL_OFFSET: begin
                    state_d.chan3_code = reg_wdata[LCS_CH3_LSB +: LCS_CODE_W]; // [RULE_06] [RULE_04]
                    state_d.chan4_code = reg_wdata[LCS_CH4_LSB +: LCS_CODE_W]; // [RULE_06] [RULE_04]
                end
                LCS_GATE_OFFSET: begin
                    // only gates 0 and 1 fit the 8-bit bus; the upper enables stay clear
                    state_d.gate_en = (GATES*LCS_EN_W)'(reg_wdata);
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                LCS_SEL_OFFSET: begin
                    state_d.rdata = {1'b0, state_q.chan4_code, 1'b0, state_q.chan3_code}; // [RULE_04] [RULE_06]
                end
                LCS_GATE_OFFSET: begin
                    state_d.rdata = state_q.gate_en[LCS_DATA_W-1:0];
                end
                LCS_STAT_OFFSET: begin
                    state_d.rdata = {6'h00, state_q.ch4_out, state_q.ch3_out};
                end
                default: begin
                    state_d.rdata = '0;
                end
            endcase
        end
    end

    // codes have no meaningful power-on value; zero is one legal choice of it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q            <= '0; // [RULE_05]
            state_q.chan3_code <= LCS_CODE_RST;
            state_q.chan4_code <= LCS_CODE_RST;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // routing and fan-out
    // ------------------------------------------------------------
    assign sel_bus.chan3_source_code = state_q.chan3_code;
    assign sel_bus.chan4_source_code = state_q.chan4_code;

    lcs_mux #(
        .IN_W (IN_W)
    ) u_mux (
        .clk            (clk),
        .rst_b          (rst_b),
        .clk_en         (clk_en),
        .cell_input_bus (cell_input_bus),
        .sel            (sel_bus.mux)
    );

    lcs_gate_fan #(
        .GATES (GATES)
    ) u_fan (
        .clk        (clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .chan3_data (sel_bus.chan3_data),
        .chan4_data (sel_bus.chan4_data),
        .gate_en    (state_q.gate_en),
        .gate_terms (gate_terms)
    );

    assign reg_rdata  = state_q.rdata;
    assign chan3_data = state_q.ch3_out;
    assign chan4_data = state_q.ch4_out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
        $past(clk_en) && $past(reg_rd) && $past(reg_addr) == LCS_SEL_OFFSET
        |-> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
        else $error("unimplemented bit read nonzero");
    AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        clk_en && reg_wr && reg_addr == LCS_SEL_OFFSET && !soft_rst
        |=> state_q.chan3_code == $past(reg_wdata[2:0]) && state_q.chan4_code == $past(reg_wdata[6:4]))
        else $error("select write not stored");
    AST_READBACK: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        clk_en && reg_rd && reg_addr == LCS_SEL_OFFSET
        |=> reg_rdata == {1'b0, $past(state_q.chan4_code), 1'b0, $past(state_q.chan3_code)})
        else $error("select readback wrong");
    AST_SOFT_KEEP: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_05]
        soft_rst |=> $stable(state_q.chan3_code) && $stable(state_q.chan4_code))
        else $error("soft reset disturbed select codes");
endmodule : lcs_top
`default_nettype wire

// ==== testbench.sv ====
// self-checking testbench for the data 3/4 input select block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import lcs_pkg::*;
;
    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    logic        clk;
    logic        rst_b;
    logic        clk_en;
    logic        soft_rst;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [15:0] cell_input_bus;
    logic        chan3_data;
    logic        chan4_data;
    logic [15:0] gate_terms;
    int          n_errors;
    int          n_compared;
    logic [31:0] seed;
    logic [2:0]  m_c3;
    logic [2:0]  m_c4;
    logic [7:0]  m_gate;

    lcs_top #(.IN_W(16), .GATES(4)) u_lcs_top (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .soft_rst(soft_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cell_input_bus(cell_input_bus),
        .chan3_data(chan3_data), .chan4_data(chan4_data), .gate_terms(gate_terms)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd

    // random bus values, then compare routing and gate terms after the sync delay
    task automatic check_path;
        logic [15:0] bus;
        logic [15:0] e;
        logic [3:0]  en;
        logic [3:0]  i4;
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            bus  = seed[15:0];
            @(posedge clk);
            cell_input_bus <= bus;
            repeat (5) @(posedge clk);
            #1;
            i4 = 4'hc + {1'b0, m_c4};
            chk("chan3_data", {15'h0, chan3_data}, {15'h0, bus[8 + m_c3]});
            chk("chan4_data", {15'h0, chan4_data}, {15'h0, bus[i4]});
            e = 16'h0000;
            for (int g = 0; g < 2; g++) begin
                en = m_gate[4*g +: 4];
                e[4*g +: 4] = {en[3] & bus[i4], en[2] & ~bus[i4], en[1] & bus[8 + m_c3], en[0] & ~bus[8 + m_c3]};
            end
            chk("gate_terms", gate_terms, e);
        end
        rd(LCS_STAT_OFFSET, {6'h00, bus[i4], bus[8 + m_c3]});
    endtask : check_path

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        rst_b = 1'b0; clk_en = 1'b1; soft_rst = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
        reg_wr = 1'b0; reg_rd = 1'b0; cell_input_bus = 16'h0000;
        n_errors = 0; n_compared = 0; seed = 32'hcf993afb;
        m_c3 = 3'h0; m_c4 = 3'h0; m_gate = 8'h00;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(LCS_SEL_OFFSET, 8'h00);
        // every code on both channels, with the unimplemented bits written high
        for (int i = 0; i < 8; i++) begin
            seed   = lfsr(seed);
            m_c4   = i[2:0];
            m_c3   = 3'(7 - i);
            m_gate = seed[23:16];
            wr(LCS_SEL_OFFSET, {1'b1, m_c4, 1'b1, m_c3});
            rd(LCS_SEL_OFFSET, {1'b0, m_c4, 1'b0, m_c3});
            wr(LCS_GATE_OFFSET, m_gate);
            rd(LCS_GATE_OFFSET, m_gate);
            check_path();
        end
        // unmapped address takes nothing and reads zero
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        rd(LCS_SEL_OFFSET, {1'b0, m_c4, 1'b0, m_c3});
        // a write strobe while the clock enable is low must be ignored
        clk_en <= 1'b0;
        wr(LCS_SEL_OFFSET, {1'b0, ~m_c4, 1'b0, ~m_c3});
        clk_en <= 1'b1;
        rd(LCS_SEL_OFFSET, {1'b0, m_c4, 1'b0, m_c3});
        // a non-power-on reset keeps the codes
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        m_gate = 8'h00;
        rd(LCS_SEL_OFFSET, {1'b0, m_c4, 1'b0, m_c3});
        rd(LCS_GATE_OFFSET, 8'h00);
        check_path();
        // power-on reset in mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        m_c3 = 3'h0;
        m_c4 = 3'h0;
        rd(LCS_SEL_OFFSET, 8'h00);
        check_path();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
